// ### shared/spc_params.svh
// Offsets, field positions, reset values and timing counts of the serial pin control block.
// Included by the pin control top module; defines only.
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_REG_CTRL     2'h0
`define SPC_REG_GPIO     2'h1
`define SPC_REG_DATA     2'h2
`define SPC_REG_STAT     2'h3
`define SPC_PORT_NONE    2'h3
`define SPC_CTRL_RX_GPIO 0
`define SPC_CTRL_TX_GPIO 1
`define SPC_CTRL_RX_CLK  2
`define SPC_CTRL_TX_CLK  3
`define SPC_CTRL_TX_FS   4
`define SPC_CTRL_RST     5'h00
`define SPC_GPIO_OE_LSB  6
`define SPC_GPIO_RST     12'h000
`define SPC_PIN_RCLK     0
`define SPC_PIN_RDATA    1
`define SPC_PIN_RFS      2
`define SPC_PIN_XCLK     3
`define SPC_PIN_XDATA    4
`define SPC_PIN_XFS      5
`define SPC_WORD_LAST    5'h0F
`define SPC_CLK_HALF     3'h2
`endif

// ### shared/spc_pkg.sv
// Types shared by the serial pin control design files.
// Assumes the params header is compiled alongside.
package spc_pkg;
	typedef enum logic [1:0] {
		SPC_TX_IDLE  = 2'b00,
		SPC_TX_ARM   = 2'b01,
		SPC_TX_SHIFT = 2'b11
	} spc_tx_state_type;
	typedef enum logic {
		SPC_RX_IDLE  = 1'b0,
		SPC_RX_SHIFT = 1'b1
	} spc_rx_state_type;
endpackage

// ### src/spc_sync.sv
// Synchroniser for signals entering a clock domain.
// Assumes the input is quasi-static or a toggle; AGREE adds the third flop and agreement.
`timescale 1ns/10ps
module spc_sync #(
	parameter int W     = 1,
	parameter bit AGREE = 1'b0
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end

	generate
		if (AGREE) begin : g_agree
			logic [W-1:0] s3_q;
			logic [W-1:0] o_q;
			logic [W-1:0] o_d;
			// A bit changes only once the second and third stages agree.
			always_comb begin
				o_d = (s3_q & ~(s2_q ^ s3_q)) | (o_q & (s2_q ^ s3_q));
			end
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s3_q <= '0;
					o_q  <= '0;
				end else begin
					s3_q <= s2_q;
					o_q  <= o_d;
				end
			end
			assign q = o_q;
		end else begin : g_plain
			assign q = s2_q;
		end
	endgenerate
endmodule

// ### src/spc_top.sv
// Contract
// - External receive clock shifts incoming data.
// - Receive GPIO enable frees receive pins.
// - Receive clock direction follows its select.
// - Receive frame pulse starts word reception.
// - Transmit clock shifts data onto pin.
// - Transmit clock input when select zero.
// - Transmit GPIO enable frees transmit pins.
// - Transmit frame pulse starts word sending.
// - Chip reset makes transmit frame input.
// - Global off tristates transmit pins.
//
// Pin control and minimal serial engines for three serial ports.
// Registers on core_clk; pin logic on a free-running link_clk.
`timescale 1ns/10ps
`include "spc_params.svh"
module spc_top
	import spc_pkg::*;
(
	// Clocks and reset.
	input  wire logic        core_clk,
	input  wire logic        link_clk,
	input  wire logic        nrst,
	// Register port.
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Global off, active low.
	input  wire logic        off_n,
	// Receive pins.
	input  wire logic [2:0]  rx_shift_clock_pin_i,
	output logic      [2:0]  rx_shift_clock_pin_o,
	output logic      [2:0]  rx_shift_clock_pin_oe,
	input  wire logic [2:0]  rx_data_pin_i,
	input  wire logic [2:0]  rx_frame_sync_pin_i,
	output logic      [2:0]  rx_frame_sync_pin_o,
	output logic      [2:0]  rx_frame_sync_pin_oe,
	// Transmit pins.
	input  wire logic [2:0]  tx_shift_clock_pin_i,
	output logic      [2:0]  tx_shift_clock_pin_o,
	output logic      [2:0]  tx_shift_clock_pin_oe,
	input  wire logic [2:0]  tx_data_pin_i,
	output logic      [2:0]  tx_data_pin_o,
	output logic      [2:0]  tx_data_pin_oe,
	input  wire logic [2:0]  tx_frame_sync_pin_i,
	output logic      [2:0]  tx_frame_sync_pin_o,
	output logic      [2:0]  tx_frame_sync_pin_oe
);
	// Core domain state.
	logic [4:0]  ctrl_q     [3];
	logic [4:0]  ctrl_d     [3];
	logic [11:0] gpio_q     [3];
	logic [11:0] gpio_d     [3];
	logic [15:0] txw_q      [3];
	logic [15:0] txw_d      [3];
	logic [2:0]  txreq_q;
	logic [2:0]  txreq_d;
	logic [15:0] rxd_q      [3];
	logic [15:0] rxd_d      [3];
	logic [2:0]  rxrdy_q;
	logic [2:0]  rxrdy_d;
	logic [2:0]  rxlast_q;
	logic [2:0]  rxlast_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic [2:0]  ack_c;
	logic [2:0]  rxt_c;
	logic [5:0]  pin_c      [3];
	// Link domain state.
	logic [5:0]  pin_raw    [3];
	logic [16:0] cfg_c      [3];
	logic [16:0] cfg_l      [3];
	logic [5:0]  pin_l      [3];
	logic [2:0]  txreq_l;
	logic        off_l;
	logic [2:0]  ack_q;
	logic [2:0]  rxt_q;
	logic [15:0] rxw_q      [3];
	logic [5:0]  po_q       [3];
	logic [5:0]  poe_q      [3];

	spc_sync #(.W(1), .AGREE(1'b1)) u_off (
		.clk   (link_clk),
		.rst_n (nrst),
		.d     (off_n),
		.q     (off_l)
	);

	spc_sync #(.W(3), .AGREE(1'b0)) u_txreq (
		.clk   (link_clk),
		.rst_n (nrst),
		.d     (txreq_q),
		.q     (txreq_l)
	);

	spc_sync #(.W(6), .AGREE(1'b0)) u_back (
		.clk   (core_clk),
		.rst_n (nrst),
		.d     ({ack_q, rxt_q}),
		.q     ({ack_c, rxt_c})
	);

	// Core side register file with write decode, read data and receive capture.
	always_comb begin
		logic [1:0] sel;
		logic       busy;
		sel      = reg_addr[3:2];
		busy     = 1'b0;
		rdata_d  = 16'h0000;
		txreq_d  = txreq_q;
		rxrdy_d  = rxrdy_q;
		rxlast_d = rxlast_q;
		for (int p = 0; p < 3; p++) begin
			busy     = txreq_q[p] ^ ack_c[p];
			ctrl_d[p] = ctrl_q[p];
			gpio_d[p] = gpio_q[p];
			txw_d[p]  = txw_q[p];
			rxd_d[p]  = rxd_q[p];
			if (reg_wr && sel == p[1:0]) begin
				unique case (reg_addr[1:0])
					`SPC_REG_CTRL: ctrl_d[p] = reg_wdata[4:0];
					`SPC_REG_GPIO: gpio_d[p] = reg_wdata[11:0];
					`SPC_REG_DATA: begin
						if (!busy) begin
							txw_d[p]   = reg_wdata;
							txreq_d[p] = ~txreq_q[p];
						end
					end
					`SPC_REG_STAT: ;
				endcase
			end
			if (reg_rd && sel == p[1:0]) begin
				unique case (reg_addr[1:0])
					`SPC_REG_CTRL: rdata_d = {11'h000, ctrl_q[p]};
					`SPC_REG_GPIO: rdata_d = {4'h0, gpio_q[p]};
					`SPC_REG_DATA: begin
						rdata_d    = rxd_q[p];
						rxrdy_d[p] = 1'b0;
					end
					`SPC_REG_STAT: rdata_d = {2'h0, pin_c[p], 6'h00, rxrdy_q[p], busy};
				endcase
			end
			// A word arriving beside a data read still sets the ready flag.
			if (rxt_c[p] != rxlast_q[p]) begin
				rxd_d[p]    = rxw_q[p];
				rxrdy_d[p]  = 1'b1;
				rxlast_d[p] = rxt_c[p];
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int p = 0; p < 3; p++) begin
				ctrl_q[p] <= `SPC_CTRL_RST;
				gpio_q[p] <= `SPC_GPIO_RST;
				txw_q[p]  <= 16'h0000;
				rxd_q[p]  <= 16'h0000;
			end
			txreq_q  <= 3'h0;
			rxrdy_q  <= 3'h0;
			rxlast_q <= 3'h0;
			rdata_q  <= 16'h0000;
		end else begin
			for (int p = 0; p < 3; p++) begin
				ctrl_q[p] <= ctrl_d[p];
				gpio_q[p] <= gpio_d[p];
				txw_q[p]  <= txw_d[p];
				rxd_q[p]  <= rxd_d[p];
			end
			txreq_q  <= txreq_d;
			rxrdy_q  <= rxrdy_d;
			rxlast_q <= rxlast_d;
			rdata_q  <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// Link side logic, one copy per port.
	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_port
			spc_tx_state_type tx_st_q;
			spc_tx_state_type tx_st_d;
			spc_rx_state_type rx_st_q;
			spc_rx_state_type rx_st_d;
			logic [2:0]  div_q;
			logic [2:0]  div_d;
			logic        dclk_q;
			logic        dclk_d;
			logic        rprev_q;
			logic        xprev_q;
			logic        seen_q;
			logic        seen_d;
			logic        fs_q;
			logic        fs_d;
			logic        dout_q;
			logic        dout_d;
			logic [4:0]  tcnt_q;
			logic [4:0]  tcnt_d;
			logic [15:0] tsh_q;
			logic [15:0] tsh_d;
			logic [4:0]  rcnt_q;
			logic [4:0]  rcnt_d;
			logic [15:0] rsh_q;
			logic [15:0] rsh_d;
			logic [15:0] rxw_d;
			logic        ack_d;
			logic        rxt_d;
			logic        rclk;
			logic        xclk;
			logic [5:0]  po_d;
			logic [5:0]  poe_d;

			assign pin_raw[gp] = {tx_frame_sync_pin_i[gp], tx_data_pin_i[gp],
				tx_shift_clock_pin_i[gp], rx_frame_sync_pin_i[gp],
				rx_data_pin_i[gp], rx_shift_clock_pin_i[gp]};
			assign cfg_c[gp] = {gpio_q[gp], ctrl_q[gp]};

			spc_sync #(.W(17), .AGREE(1'b0)) u_cfg (
				.clk   (link_clk),
				.rst_n (nrst),
				.d     (cfg_c[gp]),
				.q     (cfg_l[gp])
			);

			spc_sync #(.W(6), .AGREE(1'b1)) u_pin_l (
				.clk   (link_clk),
				.rst_n (nrst),
				.d     (pin_raw[gp]),
				.q     (pin_l[gp])
			);

			spc_sync #(.W(6), .AGREE(1'b1)) u_pin_c (
				.clk   (core_clk),
				.rst_n (nrst),
				.d     (pin_raw[gp]),
				.q     (pin_c[gp])
			);

			assign rclk = cfg_l[gp][`SPC_CTRL_RX_CLK] ? dclk_q : pin_l[gp][`SPC_PIN_RCLK];
			assign xclk = cfg_l[gp][`SPC_CTRL_TX_CLK] ? dclk_q : pin_l[gp][`SPC_PIN_XCLK];

			always_comb begin
				logic xr;
				logic rr;
				xr      = xclk & ~xprev_q;
				rr      = rclk & ~rprev_q;
				div_d   = (div_q == `SPC_CLK_HALF - 3'h1) ? 3'h0 : div_q + 3'h1;
				dclk_d  = (div_q == `SPC_CLK_HALF - 3'h1) ? ~dclk_q : dclk_q;
				tx_st_d = tx_st_q;
				seen_d  = seen_q;
				fs_d    = fs_q;
				dout_d  = dout_q;
				tcnt_d  = tcnt_q;
				tsh_d   = tsh_q;
				ack_d   = ack_q[gp];
				rx_st_d = rx_st_q;
				rcnt_d  = rcnt_q;
				rsh_d   = rsh_q;
				rxw_d   = rxw_q[gp];
				rxt_d   = rxt_q[gp];
				unique case (tx_st_q)
					SPC_TX_IDLE: begin
						if (txreq_l[gp] != seen_q) begin
							tsh_d   = txw_q[gp];
							seen_d  = txreq_l[gp];
							tx_st_d = SPC_TX_ARM;
						end
					end
					SPC_TX_ARM: begin
						if (xr) begin
							if (cfg_l[gp][`SPC_CTRL_TX_FS] ? fs_q : pin_l[gp][`SPC_PIN_XFS]) begin
								fs_d    = 1'b0;
								dout_d  = tsh_q[15];
								tsh_d   = {tsh_q[14:0], 1'b0};
								tcnt_d  = `SPC_WORD_LAST;
								tx_st_d = SPC_TX_SHIFT;
							end else begin
								fs_d = cfg_l[gp][`SPC_CTRL_TX_FS];
							end
						end
					end
					SPC_TX_SHIFT: begin
						if (xr) begin
							if (tcnt_q == 5'h00) begin
								ack_d   = seen_q;
								tx_st_d = SPC_TX_IDLE;
							end else begin
								dout_d = tsh_q[15];
								tsh_d  = {tsh_q[14:0], 1'b0};
								tcnt_d = tcnt_q - 5'h01;
							end
						end
					end
				endcase
				if (cfg_l[gp][`SPC_CTRL_TX_GPIO]) begin
					tx_st_d = SPC_TX_IDLE;
					seen_d  = seen_q;
					ack_d   = seen_q;
					fs_d    = 1'b0;
				end
				unique case (rx_st_q)
					SPC_RX_IDLE: begin
						if (rr && pin_l[gp][`SPC_PIN_RFS]) begin
							rcnt_d  = `SPC_WORD_LAST;
							rx_st_d = SPC_RX_SHIFT;
						end
					end
					SPC_RX_SHIFT: begin
						if (rr) begin
							rsh_d = {rsh_q[14:0], pin_l[gp][`SPC_PIN_RDATA]};
							if (rcnt_q == 5'h00) begin
								rxw_d   = rsh_d;
								rxt_d   = ~rxt_q[gp];
								rx_st_d = SPC_RX_IDLE;
							end else begin
								rcnt_d = rcnt_q - 5'h01;
							end
						end
					end
				endcase
				if (cfg_l[gp][`SPC_CTRL_RX_GPIO]) begin
					rx_st_d = SPC_RX_IDLE;
					rxt_d   = rxt_q[gp];
					rxw_d   = rxw_q[gp];
					po_d[2:0]  = cfg_l[gp][7:5];
					poe_d[2:0] = cfg_l[gp][13:11] & 3'h5;
				end else begin
					po_d[2:0]  = {1'b0, 1'b0, dclk_q};
					poe_d[2:0] = {1'b0, 1'b0, cfg_l[gp][`SPC_CTRL_RX_CLK]};
				end
				if (cfg_l[gp][`SPC_CTRL_TX_GPIO]) begin
					po_d[5:3]  = cfg_l[gp][10:8];
					poe_d[5:3] = cfg_l[gp][16:14];
				end else begin
					po_d[5:3]  = {fs_d, dout_d, dclk_q};
					poe_d[5:3] = {cfg_l[gp][`SPC_CTRL_TX_FS], 1'b1, cfg_l[gp][`SPC_CTRL_TX_CLK]};
				end
				if (!off_l) begin
					poe_d[5:3] = 3'h0;
				end
			end

			always_ff @(posedge link_clk or negedge nrst) begin
				if (!nrst) begin
					tx_st_q   <= SPC_TX_IDLE;
					rx_st_q   <= SPC_RX_IDLE;
					div_q     <= 3'h0;
					dclk_q    <= 1'b0;
					rprev_q   <= 1'b0;
					xprev_q   <= 1'b0;
					seen_q    <= 1'b0;
					fs_q      <= 1'b0;
					dout_q    <= 1'b0;
					tcnt_q    <= 5'h00;
					tsh_q     <= 16'h0000;
					rcnt_q    <= 5'h00;
					rsh_q     <= 16'h0000;
					rxw_q[gp] <= 16'h0000;
					ack_q[gp] <= 1'b0;
					rxt_q[gp] <= 1'b0;
					po_q[gp]  <= 6'h00;
					poe_q[gp] <= 6'h00;
				end else begin
					tx_st_q   <= tx_st_d;
					rx_st_q   <= rx_st_d;
					div_q     <= div_d;
					dclk_q    <= dclk_d;
					rprev_q   <= rclk;
					xprev_q   <= xclk;
					seen_q    <= seen_d;
					fs_q      <= fs_d;
					dout_q    <= dout_d;
					tcnt_q    <= tcnt_d;
					tsh_q     <= tsh_d;
					rcnt_q    <= rcnt_d;
					rsh_q     <= rsh_d;
					rxw_q[gp] <= rxw_d;
					ack_q[gp] <= ack_d;
					rxt_q[gp] <= rxt_d;
					po_q[gp]  <= po_d;
					poe_q[gp] <= poe_d;
				end
			end

			assign rx_shift_clock_pin_o[gp]  = po_q[gp][`SPC_PIN_RCLK];
			assign rx_shift_clock_pin_oe[gp] = poe_q[gp][`SPC_PIN_RCLK];
			assign rx_frame_sync_pin_o[gp]   = po_q[gp][`SPC_PIN_RFS];
			assign rx_frame_sync_pin_oe[gp]  = poe_q[gp][`SPC_PIN_RFS];
			assign tx_shift_clock_pin_o[gp]  = po_q[gp][`SPC_PIN_XCLK];
			assign tx_shift_clock_pin_oe[gp] = poe_q[gp][`SPC_PIN_XCLK];
			assign tx_data_pin_o[gp]         = po_q[gp][`SPC_PIN_XDATA];
			assign tx_data_pin_oe[gp]        = poe_q[gp][`SPC_PIN_XDATA];
			assign tx_frame_sync_pin_o[gp]   = po_q[gp][`SPC_PIN_XFS];
			assign tx_frame_sync_pin_oe[gp]  = poe_q[gp][`SPC_PIN_XFS];
		end
	endgenerate
endmodule

// ### test/spc_far_model.sv
// Far-side serial devices: a receive word sender and a transmit capture on port 0.
// Assumes pins are resolved by the bench; the link clock is free running.
`timescale 1ns/10ps
module spc_far_model (
	// Clock.
	input  wire logic        link_clk,
	// Transmit wires of port 0.
	input  wire logic        tx_clk,
	input  wire logic        tx_fs,
	input  wire logic        tx_dat,
	// Receive drives.
	output logic      [2:0]  rclk,
	output logic      [2:0]  rfs,
	output logic      [2:0]  rdat,
	// Captured word.
	output logic      [15:0] cap_word
);
	logic       clk_p;
	logic [4:0] cnt;
	initial begin
		rclk = 3'h0;
		rfs = 3'h0;
		rdat = 3'h0;
		cap_word = 16'h0000;
		clk_p = 1'b0;
		cnt = 5'h00;
	end
	always @(posedge link_clk) begin
		clk_p <= tx_clk;
		if (clk_p && !tx_clk) begin
			if (cnt != 5'h00) begin
				cap_word <= {cap_word[14:0], tx_dat};
				cnt <= cnt - 5'h01;
			end else if (tx_fs) begin
				cnt <= 5'h10;
			end
		end
	end
	task automatic send(input int p, input logic [15:0] w);
		logic [16:0] sh;
		sh = {~rdat[p], w};
		for (int i = 0; i < 17; i++) begin
			rfs[p] = (i == 0);
			rdat[p] = sh[16];
			sh = sh << 1;
			repeat (4) @(negedge link_clk);
			rclk[p] = 1'b1;
			repeat (4) @(negedge link_clk);
			rclk[p] = 1'b0;
		end
		rfs[p] = 1'b0;
		rdat[p] = ~rdat[p];
	endtask
endmodule

// ### test/spc_top_asserts.sv
// Checker of pin direction, global off and read port timing.
// Assumes it is bound to the pin control top module.
`timescale 1ns/10ps
module spc_top_asserts (
	// Clocks and reset.
	input wire logic        core_clk,
	input wire logic        link_clk,
	input wire logic        nrst,
	// Register port.
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// Pins.
	input wire logic        off_n,
	input wire logic [2:0]  rx_shift_clock_pin_oe,
	input wire logic [2:0]  tx_shift_clock_pin_o,
	input wire logic [2:0]  tx_shift_clock_pin_oe,
	input wire logic [2:0]  tx_data_pin_oe,
	input wire logic [2:0]  tx_frame_sync_pin_o,
	input wire logic [2:0]  tx_frame_sync_pin_oe
);
	a_off_clk_hiz: assert property (@(posedge link_clk) disable iff (!nrst)
		!off_n [*8] |-> tx_shift_clock_pin_oe == 3'h0) else $error("clock driven while off");
	a_off_data_hiz: assert property (@(posedge link_clk) disable iff (!nrst)
		!off_n [*8] |-> tx_data_pin_oe == 3'h0) else $error("data driven while off");
	a_off_frame_hiz: assert property (@(posedge link_clk) disable iff (!nrst)
		!off_n [*8] |-> tx_frame_sync_pin_oe == 3'h0) else $error("frame driven while off");
	a_reset_frame_in: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(nrst) |-> tx_frame_sync_pin_oe == 3'h0) else $error("frame output after reset");
	a_reset_rclk_in: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(nrst) |-> rx_shift_clock_pin_oe == 3'h0) else $error("rx clock output after reset");
	a_rdata_one_cycle: assert property (@(posedge core_clk) disable iff (!nrst)
		!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside its cycle");
	a_tx_clk_rate: assert property (@(posedge link_clk) disable iff (!nrst)
		$rose(tx_shift_clock_pin_o[0]) && tx_shift_clock_pin_oe[0] |=>
		(tx_shift_clock_pin_o[0] || !tx_shift_clock_pin_oe[0]) ##1
		(!tx_shift_clock_pin_o[0] || !tx_shift_clock_pin_oe[0])) else $error("clock rate wrong");
	a_fs_one_period: assert property (@(posedge link_clk) disable iff (!nrst)
		$rose(tx_frame_sync_pin_o[0]) && tx_frame_sync_pin_oe[0] |->
		(tx_frame_sync_pin_o[0] || !tx_frame_sync_pin_oe[0]) [*4] ##1
		(!tx_frame_sync_pin_o[0] || !tx_frame_sync_pin_oe[0])) else $error("frame width wrong");
	c_frame: cover property (@(posedge link_clk) $rose(tx_frame_sync_pin_o[0]));
	c_read: cover property (@(posedge core_clk) reg_rdata != 16'h0000);
	c_off: cover property (@(posedge link_clk) $fell(off_n));
endmodule
bind spc_top spc_top_asserts spc_top_asserts_inst (
	.core_clk(core_clk), .link_clk(link_clk), .nrst(nrst), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .off_n(off_n), .rx_shift_clock_pin_oe(rx_shift_clock_pin_oe),
	.tx_shift_clock_pin_o(tx_shift_clock_pin_o), .tx_shift_clock_pin_oe(tx_shift_clock_pin_oe),
	.tx_data_pin_oe(tx_data_pin_oe), .tx_frame_sync_pin_o(tx_frame_sync_pin_o),
	.tx_frame_sync_pin_oe(tx_frame_sync_pin_oe));

// ### test/spc_top_test.sv
// Testbench of the serial pin control block.
// Assumes the far model and checker are compiled beside the design.
`timescale 1ns/10ps
module spc_top_test;
	logic        core_clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        off_n = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata, cap_word, d;
	logic [2:0]  rck_o, rck_oe, rfs_o, rfs_oe, tck_o, tck_oe, tdt_o, tdt_oe, tfs_o, tfs_oe;
	logic [2:0]  f_rck, f_rfs, f_rdt;
	int          num_errors = 0;
	int          checks_done = 0;
	always #4 core_clk = ~core_clk;
	initial begin
		#37;
		forever #80 link_clk = ~link_clk;
	end
	spc_top spc_top_inst (.core_clk(core_clk), .link_clk(link_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .off_n(off_n),
		.rx_shift_clock_pin_i((rck_oe & rck_o) | (~rck_oe & f_rck)),
		.rx_shift_clock_pin_o(rck_o), .rx_shift_clock_pin_oe(rck_oe), .rx_data_pin_i(f_rdt),
		.rx_frame_sync_pin_i((rfs_oe & rfs_o) | (~rfs_oe & f_rfs)),
		.rx_frame_sync_pin_o(rfs_o), .rx_frame_sync_pin_oe(rfs_oe),
		.tx_shift_clock_pin_i(tck_o ^ ~tck_oe), .tx_shift_clock_pin_o(tck_o),
		.tx_shift_clock_pin_oe(tck_oe), .tx_data_pin_i(tdt_o ^ ~tdt_oe), .tx_data_pin_o(tdt_o),
		.tx_data_pin_oe(tdt_oe), .tx_frame_sync_pin_i(tfs_o ^ ~tfs_oe),
		.tx_frame_sync_pin_o(tfs_o), .tx_frame_sync_pin_oe(tfs_oe));
	// Released transmit clock and frame lines are pulled low at the far device.
	spc_far_model spc_far_model_inst (.link_clk(link_clk), .tx_clk(tck_o[0] & tck_oe[0]),
		.tx_fs(tfs_o[0] & tfs_oe[0]), .tx_dat(tdt_o[0] ^ ~tdt_oe[0]), .rclk(f_rck),
		.rfs(f_rfs), .rdat(f_rdt), .cap_word(cap_word));
	task automatic print_verdict;
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic links(input int n);
		repeat (n) @(posedge link_clk);
		#1;
	endtask
	initial begin
		#500000;
		num_errors++;
		print_verdict;
	end
	initial begin
		links(6);
		@(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int p = 0; p < 4; p++) begin
			wr(4'(p * 4 + 1), 16'h0000);
			rd(4'(p * 4));
			chk(d, 16'h0000);
		end
		wr(4'hC, 16'h001F);
		rd(4'hC);
		chk(d, 16'h0000);
		chk({13'h0, tfs_oe}, 16'h0000);
		wr(4'h0, 16'h001C);
		links(8);
		chk({7'h0, rck_oe, tck_oe, tfs_oe}, 16'h0049);
		wr(4'h2, 16'h9C35);
		links(100);
		rd(4'h3);
		chk(d & 16'h0003, 16'h0000);
		chk(cap_word, 16'h9C35);
		spc_far_model_inst.send(1, 16'hA5C3);
		links(8);
		rd(4'h7);
		chk(d & 16'h0003, 16'h0002);
		rd(4'h6);
		chk(d, 16'hA5C3);
		rd(4'h7);
		chk(d & 16'h0003, 16'h0000);
		wr(4'h8, 16'h0003);
		wr(4'h9, 16'h0F6A);
		links(8);
		chk({6'h0, rck_oe[2], rfs_oe[2], tck_oe[2], tdt_oe[2], tfs_oe[2], rck_o[2], rfs_o[2],
			tck_o[2], tdt_o[2], tfs_o[2]}, 16'h03E5);
		spc_far_model_inst.send(2, 16'h1234);
		links(8);
		rd(4'hB);
		chk(d & 16'h0002, 16'h0000);
		@(posedge core_clk);
		off_n <= 1'b0;
		links(10);
		chk({4'h0, rck_oe, tck_oe, tdt_oe, tfs_oe}, 16'h0A00);
		@(posedge core_clk);
		off_n <= 1'b1;
		links(10);
		chk({14'h0, tck_oe[0], tfs_oe[0]}, 16'h0003);
		@(posedge core_clk);
		nrst <= 1'b0;
		links(3);
		chk({13'h0, tfs_oe}, 16'h0000);
		@(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd(4'h0);
		chk(d, 16'h0000);
		links(4);
		chk({13'h0, tfs_oe}, 16'h0000);
		print_verdict;
	end
endmodule
